// ==== rtl/swt_pkg.sv ====
// Purpose: shared constants and types for the sleep wake timer
// Assumes: APB word registers, 8-bit address
// Notes:   offsets, reset values and counts live here only
package swt_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG    = 8'h00;
   localparam logic [7:0] ADDR_MANT_HIGH = 8'h04;
   localparam logic [7:0] ADDR_MANT_LOW  = 8'h08;
   localparam logic [7:0] ADDR_EXP_STATE = 8'h0C;
   localparam logic [7:0] ADDR_WINDOW    = 8'h10;
   localparam logic [7:0] ADDR_CLOCK_CFG = 8'h14;
   localparam logic [7:0] ADDR_INT_EN    = 8'h18;
   localparam logic [7:0] ADDR_INT_STAT  = 8'h1C;
   localparam logic [7:0] ADDR_PIN_MODE  = 8'h20;
   localparam logic [7:0] ADDR_STATUS    = 8'h24;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [6:0] RST_CONFIG    = 7'h00;
   localparam logic [7:0] RST_MANT_HIGH = 8'h00;
   localparam logic [7:0] RST_MANT_LOW  = 8'h01;
   localparam logic [5:0] RST_EXP_STATE = 6'h00;
   localparam logic [7:0] RST_WINDOW    = 8'h00;
   localparam logic [2:0] RST_CLOCK_SEL = 3'h0;
   localparam logic [2:0] RST_INT_EN    = 3'h0;
   localparam logic [5:0] RST_PIN_MODE  = 6'h00;
   localparam logic [7:0] RST_TRIM      = 8'h80;
   // ----------------------------------------------------------------
   // field positions, encodings and counts
   // ----------------------------------------------------------------
   localparam int         ST_EXPIRED      = 0;
   localparam int         ST_BATTERY      = 1;
   localparam int         ST_CAL_DONE     = 2;
   localparam int         EXP_SLEEP_BIT   = 5;
   localparam logic [2:0] CLK_SEL_XTAL    = 3'h1;
   localparam logic [5:0] GPIO_MODE_WAKE  = 6'h0E;
   localparam logic [5:0] IRQ_MODE_WAKE   = 6'h27;
   localparam logic [33:0] UNIT_TICKS     = 34'h000000004;
   localparam int         SLOW_CLK_HZ     = 32768;
   localparam int         REF_CLK_HZ      = 30000000;
   localparam int         CAL_SLOW_TICKS  = 16;
   localparam logic [15:0] REF_CAL_COUNT  =
      16'(REF_CLK_HZ / SLOW_CLK_HZ * CAL_SLOW_TICKS);
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] recalibration_interval;
      logic       cal_enable;
      logic       duty_cycle_enable;
      logic       battery_check_enable;
      logic       wake_timer_enable;
   } swt_config_type;
   typedef enum logic [1:0] {CAL_IDLE, CAL_XTAL_WAIT, CAL_MEASURE} swt_cal_state_type;
endpackage : swt_pkg

// ==== rtl/swt_sleep_wake_timer.sv ====
// Purpose: periodic wake timer with RC recalibration and APB registers
// Assumes: sleep_entry, power_up_cmd, shutdown_exit, xtal_ready and
//          xtal_ref_tick come from logic on clk
// Notes:   slow clock pins are synchronised and edge detected
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
module swt_sleep_wake_timer #(
   parameter int ADDR_WIDTH = 8
) (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire logic                  rc_clk_32k,
   input  wire logic                  xtal_clk_32k,
   input  wire logic                  sleep_entry,
   input  wire logic                  power_up_cmd,
   input  wire logic                  shutdown_exit,
   input  wire logic                  xtal_ready,
   input  wire logic                  xtal_ref_tick,
   output logic                       xtal_enable,
   output logic [7:0]                 rc_trim,
   output logic                       wake_to_ready,
   output logic                       wake_to_sleep,
   output logic                       rx_start,
   output logic                       rx_window_active,
   output logic                       battery_check_start,
   output logic                       gpio_wake_out,
   output logic                       irq,
   output logic                       interrupt_out_n
);
   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   swt_pkg::swt_config_type     cfg;
   swt_pkg::swt_cal_state_type  cal_state;
   logic [7:0]  wake_mantissa_high;
   logic [7:0]  wake_mantissa_low;
   logic [5:0]  wake_exponent_and_state;
   logic [7:0]  duty_cycle_window;
   logic [2:0]  slow_clock_source_select;
   logic [2:0]  chip_interrupt_enables;
   logic [2:0]  int_status;
   logic [5:0]  pin_function_mode;
   logic [5:0]  interrupt_pin_mode;
   logic [2:0]  rc_sync;
   logic [2:0]  xt_sync;
   logic        rc_level;
   logic        xt_level;
   logic        running;
   logic [33:0] prescale;
   logic [15:0] mant_count;
   logic [7:0]  window_count;
   logic [7:0]  cal_wake_count;
   logic        cal_pending;
   logic [4:0]  cal_slow_cnt;
   logic [15:0] ref_cnt;
   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // pready is registered, so every access takes three cycles
   wire         bus_phase  = psel & penable & ~pready;
   wire         bus_done   = psel & penable & pready;
   wire         wr_done    = bus_done & pwrite;
   wire [7:0]   addr       = 8'(paddr);
   wire         hit_config = addr == swt_pkg::ADDR_CONFIG;
   wire         hit_mhigh  = addr == swt_pkg::ADDR_MANT_HIGH;
   wire         hit_mlow   = addr == swt_pkg::ADDR_MANT_LOW;
   wire         hit_exp    = addr == swt_pkg::ADDR_EXP_STATE;
   wire         hit_window = addr == swt_pkg::ADDR_WINDOW;
   wire         hit_clock  = addr == swt_pkg::ADDR_CLOCK_CFG;
   wire         hit_int_en = addr == swt_pkg::ADDR_INT_EN;
   wire         hit_stat   = addr == swt_pkg::ADDR_INT_STAT;
   wire         hit_pin    = addr == swt_pkg::ADDR_PIN_MODE;
   wire         hit_status = addr == swt_pkg::ADDR_STATUS;
   wire         mapped     = hit_config | hit_mhigh | hit_mlow | hit_exp | hit_window |
                             hit_clock | hit_int_en | hit_stat | hit_pin | hit_status;
   // read of interrupt status clears it
   wire         stat_read  = bus_done & ~pwrite & hit_stat;
   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [31:0]  read_value =
      hit_config ? {25'h0, cfg} :
      hit_mhigh  ? {24'h0, wake_mantissa_high} :
      hit_mlow   ? {24'h0, wake_mantissa_low} :
      hit_exp    ? {26'h0, wake_exponent_and_state} :
      hit_window ? {24'h0, duty_cycle_window} :
      hit_clock  ? {29'h0, slow_clock_source_select} :
      hit_int_en ? {29'h0, chip_interrupt_enables} :
      hit_stat   ? {29'h0, int_status} :
      hit_pin    ? {18'h0, interrupt_pin_mode, 2'h0, pin_function_mode} :
      hit_status ? {16'h0, rc_trim, 6'h0, cal_state != swt_pkg::CAL_IDLE, running} :
      32'h0;
   // apb answer, one wait state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= bus_phase;
         prdata  <= bus_phase & ~pwrite ? read_value : 32'h0;
         pslverr <= bus_phase & ~mapped;
      end
   end
   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // writes take effect only at the completing edge
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg                      <= swt_pkg::RST_CONFIG;
         wake_mantissa_high       <= swt_pkg::RST_MANT_HIGH;
         wake_mantissa_low        <= swt_pkg::RST_MANT_LOW;
         wake_exponent_and_state  <= swt_pkg::RST_EXP_STATE;
         duty_cycle_window        <= swt_pkg::RST_WINDOW;
         slow_clock_source_select <= swt_pkg::RST_CLOCK_SEL;
         chip_interrupt_enables   <= swt_pkg::RST_INT_EN;
         pin_function_mode        <= swt_pkg::RST_PIN_MODE;
         interrupt_pin_mode       <= swt_pkg::RST_PIN_MODE;
      end else if (wr_done) begin
         if (hit_config) cfg <= pwdata[6:0];
         if (hit_mhigh) wake_mantissa_high <= pwdata[7:0];
         if (hit_mlow) wake_mantissa_low <= pwdata[7:0];
         if (hit_exp) wake_exponent_and_state <= pwdata[5:0];
         if (hit_window) duty_cycle_window <= pwdata[7:0];
         if (hit_clock) slow_clock_source_select <= pwdata[2:0];
         if (hit_int_en) chip_interrupt_enables <= pwdata[2:0];
         if (hit_pin) begin
            pin_function_mode  <= pwdata[5:0];
            interrupt_pin_mode <= pwdata[13:8];
         end
      end
   end
   // ----------------------------------------------------------------
   // slow clock synchronisers
   // ----------------------------------------------------------------
   // three stages; a level counts once stages two and three agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rc_sync  <= 3'h0;
         xt_sync  <= 3'h0;
         rc_level <= 1'b0;
         xt_level <= 1'b0;
      end else begin
         rc_sync <= {rc_sync[1:0], rc_clk_32k};
         xt_sync <= {xt_sync[1:0], xtal_clk_32k};
         if (rc_sync[1] == rc_sync[2]) rc_level <= rc_sync[2];
         if (xt_sync[1] == xt_sync[2]) xt_level <= xt_sync[2];
      end
   end
   wire rc_tick   = rc_sync[1] & rc_sync[2] & ~rc_level;
   wire xt_tick   = xt_sync[1] & xt_sync[2] & ~xt_level;
   // other codes fall back to the RC source
   wire slow_tick = slow_clock_source_select == swt_pkg::CLK_SEL_XTAL ? xt_tick : rc_tick;
   // ----------------------------------------------------------------
   // period counting
   // ----------------------------------------------------------------
   wire [15:0] period_mantissa  = {wake_mantissa_high, wake_mantissa_low};
   wire [4:0]  period_exponent  = wake_exponent_and_state[4:0];
   wire        post_wake_sleep  = wake_exponent_and_state[swt_pkg::EXP_SLEEP_BIT];
   // one unit is 4 * 2^exponent slow ticks
   wire [33:0] unit_last_value  = (swt_pkg::UNIT_TICKS << period_exponent) - 34'h1;
   wire        unit_end         = slow_tick & (prescale == unit_last_value);
   // zero mantissa never expires
   wire        expiry           = running & unit_end & (period_mantissa != 16'h0) &
                                  (mant_count == period_mantissa - 16'h1);
   // counts only while armed at sleep entry
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         running <= 1'b0;
      end else begin
         running <= cfg.wake_timer_enable & (running | sleep_entry);
      end
   end
   // reload on expiry and keep going
   always_ff @(posedge clk) begin
      if (!reset_n || !running || expiry) begin
         prescale   <= 34'h0;
         mant_count <= 16'h0;
      end else if (unit_end) begin
         prescale   <= 34'h0;
         mant_count <= mant_count + 16'h1;
      end else if (slow_tick) begin
         prescale   <= prescale + 34'h1;
      end
   end
   // ----------------------------------------------------------------
   // wake actions
   // ----------------------------------------------------------------
   wire window_on = cfg.duty_cycle_enable & (duty_cycle_window != 8'h0);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wake_to_ready       <= 1'b0;
         wake_to_sleep       <= 1'b0;
         rx_start            <= 1'b0;
         battery_check_start <= 1'b0;
      end else begin
         wake_to_ready       <= expiry & ~post_wake_sleep;
         wake_to_sleep       <= expiry & post_wake_sleep;
         rx_start            <= expiry & cfg.duty_cycle_enable;
         battery_check_start <= expiry & cfg.battery_check_enable;
      end
   end
   // receive window counted in the same units as the period
   always_ff @(posedge clk) begin
      if (!reset_n || !running) begin
         rx_window_active <= 1'b0;
         window_count     <= 8'h0;
      end else if (expiry) begin
         rx_window_active <= window_on;
         window_count     <= 8'h0;
      end else if (rx_window_active && unit_end) begin
         if (window_count == duty_cycle_window - 8'h1) rx_window_active <= 1'b0;
         window_count <= window_count + 8'h1;
      end
   end
   // ----------------------------------------------------------------
   // calibration
   // ----------------------------------------------------------------
   // interval is 2^field wake periods
   wire [7:0] cal_wakes = (8'h01 << cfg.recalibration_interval) - 8'h01;
   wire       cal_due   = expiry & cfg.cal_enable & (cal_wake_count == cal_wakes);
   wire       cal_req   = power_up_cmd | shutdown_exit | cal_due;
   wire       cal_start = cal_pending & (cal_state == swt_pkg::CAL_IDLE);
   wire       cal_done  = (cal_state == swt_pkg::CAL_MEASURE) & rc_tick &
                          (cal_slow_cnt == 5'(swt_pkg::CAL_SLOW_TICKS - 1));
   always_ff @(posedge clk) begin
      if (!reset_n || !cfg.cal_enable) begin
         cal_wake_count <= 8'h0;
      end else if (expiry) begin
         cal_wake_count <= cal_due ? 8'h0 : cal_wake_count + 8'h1;
      end
   end
   // a new request wins over the take of an old one
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cal_pending <= 1'b0;
      end else begin
         cal_pending <= cal_req | (cal_pending & ~cal_start);
      end
   end
   // crystal on, count reference ticks over RC ticks, trim by one
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cal_state    <= swt_pkg::CAL_IDLE;
         xtal_enable  <= 1'b0;
         cal_slow_cnt <= 5'h0;
         ref_cnt      <= 16'h0;
         rc_trim      <= swt_pkg::RST_TRIM;
      end else begin
         case (cal_state)
            swt_pkg::CAL_IDLE: begin
               if (cal_start) begin
                  cal_state   <= swt_pkg::CAL_XTAL_WAIT;
                  xtal_enable <= 1'b1;
               end
            end
            swt_pkg::CAL_XTAL_WAIT: begin
               cal_slow_cnt <= 5'h0;
               ref_cnt      <= 16'h0;
               if (xtal_ready && rc_tick) cal_state <= swt_pkg::CAL_MEASURE;
            end
            swt_pkg::CAL_MEASURE: begin
               if (xtal_ref_tick) ref_cnt <= ref_cnt + 16'h1;
               if (rc_tick) cal_slow_cnt <= cal_slow_cnt + 5'h1;
               if (cal_done) begin
                  cal_state   <= swt_pkg::CAL_IDLE;
                  xtal_enable <= 1'b0;
                  // more reference ticks means RC runs slow
                  if (ref_cnt > swt_pkg::REF_CAL_COUNT && rc_trim != 8'hFF)
                     rc_trim <= rc_trim + 8'h1;
                  else if (ref_cnt < swt_pkg::REF_CAL_COUNT && rc_trim != 8'h00)
                     rc_trim <= rc_trim - 8'h1;
               end
            end
            default: begin
               cal_state   <= swt_pkg::CAL_IDLE;
               xtal_enable <= 1'b0;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // interrupt status and outputs
   // ----------------------------------------------------------------
   wire [2:0] status_events = {cal_done, expiry & cfg.battery_check_enable, expiry};
   // set wins over the read clear
   wire [2:0] next_int_status = (int_status & {3{~stat_read}}) | status_events;
   wire       wake_pin_irq    = (interrupt_pin_mode == swt_pkg::IRQ_MODE_WAKE) &
                                int_status[swt_pkg::ST_EXPIRED];
   wire       next_irq        = (|(int_status & chip_interrupt_enables)) | wake_pin_irq;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         int_status      <= 3'h0;
         irq             <= 1'b0;
         interrupt_out_n <= 1'b1;
         gpio_wake_out   <= 1'b0;
      end else begin
         int_status      <= next_int_status;
         irq             <= next_irq;
         interrupt_out_n <= ~next_irq;
         gpio_wake_out   <= (pin_function_mode == swt_pkg::GPIO_MODE_WAKE) &
                            int_status[swt_pkg::ST_EXPIRED];
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_irq_on_expiry;
      expiry && chip_interrupt_enables[swt_pkg::ST_EXPIRED] |-> ##2 irq && !interrupt_out_n;
   endproperty
   a_irq_on_expiry: assert property (p_irq_on_expiry)
      else $error("expiry did not raise the interrupt");
   property p_reload;
      expiry && cfg.wake_timer_enable |=> prescale == 34'h0 && mant_count == 16'h0 && running;
   endproperty
   a_reload: assert property (p_reload)
      else $error("counter not reloaded after expiry");
   property p_post_state;
      expiry |=> wake_to_sleep == $past(post_wake_sleep) && wake_to_ready != wake_to_sleep;
   endproperty
   a_post_state: assert property (p_post_state)
      else $error("wrong state after wake");
   property p_battery;
      expiry && cfg.battery_check_enable |=> battery_check_start && int_status[1];
   endproperty
   a_battery: assert property (p_battery)
      else $error("battery check missing at expiry");
   property p_duty_cycle;
      expiry |=> rx_start == $past(cfg.duty_cycle_enable) && rx_window_active == $past(window_on);
   endproperty
   a_duty_cycle: assert property (p_duty_cycle)
      else $error("receive start or window wrong at wake");
   property p_idle_silent;
      !running |=> !wake_to_ready && !wake_to_sleep && !rx_start;
   endproperty
   a_idle_silent: assert property (p_idle_silent)
      else $error("wake without an armed timer");
   property p_power_up_cal;
      power_up_cmd && cal_state == swt_pkg::CAL_IDLE && !cal_pending |-> ##2 xtal_enable;
   endproperty
   a_power_up_cal: assert property (p_power_up_cal)
      else $error("power-up did not start calibration");
   property p_read_clear;
      stat_read && status_events == 3'h0 |=> int_status == 3'h0;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("status read did not clear");
   property p_irq_drop;
      (int_status & chip_interrupt_enables) == 3'h0 &&
      interrupt_pin_mode != swt_pkg::IRQ_MODE_WAKE |=> !irq && interrupt_out_n;
   endproperty
   a_irq_drop: assert property (p_irq_drop)
      else $error("interrupt held with nothing pending");
   c_expiry: cover property (expiry ##1 wake_to_sleep);
   c_cal_done: cover property (cal_done ##1 !xtal_enable);
   c_window_end: cover property (rx_window_active ##1 !rx_window_active);
   c_read_clear: cover property (stat_read && int_status != 3'h0);
endmodule : swt_sleep_wake_timer

// ==== verification/swt_far_model.sv ====
// Purpose: far side: slow clocks, crystal reference, crystal ready
// Assumes: slow clocks shortened to 40 and 46 clk periods
// Notes:   ready follows enable one cycle late
`timescale 1ns/100ps
module swt_far_model (
   input  wire logic clk,
   input  wire logic xtal_enable,
   output logic      rc_clk_32k = 1'b0,
   output logic      xtal_clk_32k = 1'b0,
   output logic      xtal_ref_tick = 1'b0,
   output logic      xtal_ready = 1'b0
);
   int cnt = 0;
   // unrelated slow clocks; reference ticks only while the crystal runs
   always @(posedge clk) begin
      cnt <= cnt + 1;
      rc_clk_32k <= cnt % 40 < 20;
      xtal_clk_32k <= cnt % 46 < 23;
      xtal_ref_tick <= xtal_enable & cnt[0];
      xtal_ready <= xtal_enable;
   end
endmodule : swt_far_model

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the sleep wake timer
// Assumes: rc ticks every 40 cycles, crystal every 46
// Notes:   every wait is bounded; a spent bound fails the run
`timescale 1ns/100ps
module tb_top;
   logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        sleep_entry = 1'b0, pready, pslverr, rerr, xtal_enable, irq, interrupt_out_n;
   logic        rc_clk_32k, xtal_clk_32k, xtal_ref_tick, xtal_ready, gpio_wake_out;
   logic        wake_to_ready, wake_to_sleep, rx_start, rx_window_active, battery_check_start;
   logic [1:0]  cal_req = 2'h0;
   logic [7:0]  paddr = 8'h00, rc_trim;
   logic [31:0] pwdata = 32'h0, prdata, rq;
   int          fails = 0, compares = 0, n, s, k, n_slp = 0, n_rdy = 0, n_rx = 0, n_bat = 0;
   wire  [2:0]  mon = {rx_window_active, irq, xtal_enable};
   swt_sleep_wake_timer i_swt_sleep_wake_timer (.clk, .reset_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .rc_clk_32k, .xtal_clk_32k, .sleep_entry,
      .power_up_cmd(cal_req[0]), .shutdown_exit(cal_req[1]), .xtal_ready, .xtal_ref_tick,
      .xtal_enable, .rc_trim, .wake_to_ready, .wake_to_sleep, .rx_start, .rx_window_active,
      .battery_check_start, .gpio_wake_out, .irq, .interrupt_out_n);
   swt_far_model i_swt_far_model (.clk, .xtal_enable, .rc_clk_32k, .xtal_clk_32k,
      .xtal_ref_tick, .xtal_ready);
   always #5 clk = ~clk;
   // count the one-cycle wake pulses
   always @(posedge clk) begin
      n_slp <= n_slp + int'(wake_to_sleep);
      n_rdy <= n_rdy + int'(wake_to_ready);
      n_rx <= n_rx + int'(rx_start);
      n_bat <= n_bat + int'(battery_check_start);
   end
   task automatic final_report();
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one apb transfer; held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
      if (i == 20) begin
         fails++;
         final_report();
      end
      rq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // bounded wait for bit b of mon to reach v; n holds the cycles spent
   task automatic wait_mon(input int b, input logic v);
      for (n = 0; n < 3000 && mon[b] !== v; n++) @(posedge clk);
      if (n == 3000) begin
         fails++;
         final_report();
      end
   endtask : wait_mon
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      apb(1'b0, swt_pkg::ADDR_MANT_LOW, 32'h0);
      chk("mant low", {rerr, rq[30:0]}, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rerr, rq[30:0]}, 32'h80000000);
      for (s = 0; s < 2; s++) begin
         @(posedge clk) cal_req <= 2'h1 << s;
         @(posedge clk) cal_req <= 2'h0;
         wait_mon(0, 1'b1);
         wait_mon(0, 1'b0);
         chk("trim", rc_trim, 32'h7F - s);
         apb(1'b0, swt_pkg::ADDR_INT_STAT, 32'h0);
         chk("cal stat", rq, 32'h4);
      end
      apb(1'b1, swt_pkg::ADDR_MANT_LOW, 32'h2);
      apb(1'b1, swt_pkg::ADDR_EXP_STATE, 32'h21);
      apb(1'b1, swt_pkg::ADDR_WINDOW, 32'h1);
      apb(1'b1, swt_pkg::ADDR_INT_EN, 32'h1);
      for (s = 0; s < 2; s++) begin
         apb(1'b1, swt_pkg::ADDR_CLOCK_CFG, 32'(s));
         apb(1'b1, swt_pkg::ADDR_CONFIG, 32'h7);
         @(posedge clk) sleep_entry <= 1'b1;
         @(posedge clk) sleep_entry <= 1'b0;
         for (k = 0; k < 2; k++) begin
            wait_mon(1, 1'b1);
            // the first period after arming may lose up to one tick of phase
            chk("period", 32'(n > (15 + k) * (40 + 6 * s) - 30 && n < 16 * (40 + 6 * s) + 50),
               32'h1);
            chk("irq pin", interrupt_out_n, 32'h0);
            chk("wakes", {n_slp[7:0], n_rdy[7:0], n_rx[7:0], n_bat[7:0]},
               {4{8'(2 * s + k + 1)}} & 32'hFF00FFFF);
            apb(1'b0, swt_pkg::ADDR_INT_STAT, 32'h0);
            chk("int stat", rq, 32'h3);
            wait_mon(1, 1'b0);
            chk("irq off", interrupt_out_n, 32'h1);
         end
      end
      apb(1'b1, swt_pkg::ADDR_INT_EN, 32'h0);
      // let the running window end, then time one whole window
      wait_mon(2, 1'b0);
      wait_mon(2, 1'b1);
      wait_mon(2, 1'b0);
      chk("window", 32'(n > 8 * 46 - 3 && n < 8 * 46 + 3), 32'h1);
      chk("masked", irq, 32'h0);
      apb(1'b0, swt_pkg::ADDR_INT_STAT, 32'h0);
      chk("mask stat", rq, 32'h3);
      // wake to ready, expiry routed to both pins
      apb(1'b1, swt_pkg::ADDR_EXP_STATE, 32'h1);
      apb(1'b1, swt_pkg::ADDR_PIN_MODE, 32'h270E);
      apb(1'b0, swt_pkg::ADDR_PIN_MODE, 32'h0);
      chk("pin mode", rq, 32'h270E);
      wait_mon(1, 1'b1);
      chk("gpio wake", gpio_wake_out, 32'h1);
      chk("irq mode", interrupt_out_n, 32'h0);
      chk("ready", n_rdy, 32'h1);
      // recalibrate every second expiry
      apb(1'b1, swt_pkg::ADDR_CONFIG, 32'h19);
      wait_mon(0, 1'b1);
      chk("cal period", 32'(n > 16 * 46), 32'h1);
      wait_mon(0, 1'b0);
      chk("recal trim", rc_trim, 32'h7D);
      apb(1'b1, swt_pkg::ADDR_CONFIG, 32'h0);
      apb(1'b0, swt_pkg::ADDR_STATUS, 32'h0);
      chk("stopped", rq, 32'h7D00);
      final_report();
   end
endmodule : tb_top
